// ==== hdl/sbra_pkg.sv ====
//----------------------------------------------------------------
// Behaviour
// [R01] Grant time-out detection runs only while mask bit 7 is set; resets cleared.
// [R02] Time-out window is a fixed 16 bus clocks.
// [R03] Window counts from bus idle with grant held; no frame by end means dead.
// [R04] Auto-masking on time-out applies only while mask bit 6 is set; resets cleared.
// [R05] Mask bit n set ignores request n; clear arbitrates it; all reset to 0.
// [R06] One time-out status bit per request, bits 5..0, set on time-out.
// [R07] Status bits 7:6 read zero and ignore writes.
// [R08] Software clears auto-mask before clearing status bits after a time-out.
// [R09] Writing 1 clears a status bit; writing 0 leaves it.
// [R10] Link reset, global reset and power-on reset all restore defaults.
// [R11] Unmasked requests arbitrate by two-tier rotating priority.
// [R12] With auto-mask on, a timed-out request is excluded and grant moves on.
//----------------------------------------------------------------
package sbra_pkg;
    localparam int NUM_REQ = 6;
    localparam logic [7:0] ADDR_REQUEST_MASK = 8'hdd;
    localparam logic [7:0] ADDR_TIMEOUT_STATUS = 8'hde;
    localparam logic [7:0] RESET_REQUEST_MASK = 8'h00;
    localparam logic [7:0] RESET_TIMEOUT_STATUS = 8'h00;
    localparam int BIT_TIMEOUT_ENABLE = 7;
    localparam int BIT_AUTO_MASK = 6;
    localparam logic [7:0] STATUS_WRITABLE = 8'h3f;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT_WINDOW_CLOCKS = 16;
    localparam int TIMEOUT_CYCLES = TIMEOUT_WINDOW_CLOCKS * 10 / CLK_PERIOD_NS;
    localparam logic [4:0] TIMEOUT_LAST = 5'(TIMEOUT_CYCLES - 1);
    typedef enum logic [1:0] {SBRA_IDLE, SBRA_WAIT, SBRA_BUSY} sbra_state_t;
endpackage : sbra_pkg

// ==== hdl/sbra_rotate.sv ====
// Rotating pick among a request vector, starting after the last winner
module sbra_rotate #(
    parameter int N = 6
) (
    input wire logic [N-1:0] i_req,
    input wire logic [$clog2(N)-1:0] i_last,
    output logic o_any,
    output logic [$clog2(N)-1:0] o_pick
);
    always_comb begin
        int idx;
        idx = 0;
        o_any = 1'b0;
        o_pick = i_last;
        for (int k = N; k >= 1; k--) begin
            idx = (int'(i_last) + k) % N;
            if (i_req[idx]) begin
                o_any = 1'b1;
                o_pick = ($clog2(N))'(idx);
            end
        end
    end
endmodule // sbra_rotate

// ==== hdl/sbra_arbiter.sv ====
module sbra_arbiter #(
    parameter int N = sbra_pkg::NUM_REQ
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_reset_pin_n,
    input wire logic i_global_reset_pin_n,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    input wire logic [N-1:0] i_req_n,
    input wire logic [N-1:0] i_high_tier,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    output logic [N-1:0] o_gnt_n,
    output logic [N-1:0] o_request_timed_out_flags,
    output logic o_timeout_pulse
);
    localparam int W = $clog2(N);

    //----------------------------------------------------------------
    // Input synchronisers
    //----------------------------------------------------------------
    logic [N+3:0] sync1;
    logic [N+3:0] sync2;
    always_ff @(posedge i_clk) begin
        sync1 <= {i_link_reset_pin_n, i_global_reset_pin_n, i_frame_n, i_irdy_n, i_req_n};
        sync2 <= sync1;
    end
    wire logic link_rst_n = sync2[N+3];
    wire logic glob_rst_n = sync2[N+2];
    wire logic frame_act = ~sync2[N+1];
    wire logic irdy_act = ~sync2[N];
    wire logic [N-1:0] req = ~sync2[N-1:0];
    // Power-on, link and global resets are all folded into one reset
    wire logic any_rst = i_rst | ~link_rst_n | ~glob_rst_n; // [R10]

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    logic [7:0] request_mask, next_request_mask;
    logic [7:0] timeout_status, next_timeout_status;
    logic [7:0] rdata, next_rdata;
    logic [N-1:0] timeout_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    wire logic to_en = request_mask[sbra_pkg::BIT_TIMEOUT_ENABLE]; // [R01]
    wire logic auto_en = request_mask[sbra_pkg::BIT_AUTO_MASK]; // [R04]

    always_comb begin
        next_request_mask = request_mask;
        next_timeout_status = timeout_status;
        next_rdata = rdata;
        if (i_cfg_wr && hit(i_cfg_addr, sbra_pkg::ADDR_REQUEST_MASK)) begin
            next_request_mask = i_cfg_wdata;
        end
        if (i_cfg_wr && hit(i_cfg_addr, sbra_pkg::ADDR_TIMEOUT_STATUS)) begin
            // Status stays locked while auto-mask is on; software must drop it first
            if (!auto_en) begin // [R08]
                next_timeout_status = timeout_status & ~(i_cfg_wdata & sbra_pkg::STATUS_WRITABLE); // [R09]
            end
        end
        // Set wins over a clear in the same cycle
        next_timeout_status[N-1:0] = next_timeout_status[N-1:0] | timeout_set; // [R06]
        next_timeout_status[7:N] = '0; // [R07]
        if (i_cfg_rd) begin
            if (hit(i_cfg_addr, sbra_pkg::ADDR_REQUEST_MASK)) begin
                next_rdata = request_mask;
            end else if (hit(i_cfg_addr, sbra_pkg::ADDR_TIMEOUT_STATUS)) begin
                next_rdata = timeout_status & sbra_pkg::STATUS_WRITABLE; // [R07]
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            request_mask <= sbra_pkg::RESET_REQUEST_MASK; // [R10]
            timeout_status <= sbra_pkg::RESET_TIMEOUT_STATUS;
            rdata <= 8'h00;
        end else begin
            request_mask <= next_request_mask;
            timeout_status <= next_timeout_status;
            rdata <= next_rdata;
        end
    end

    //----------------------------------------------------------------
    // Eligibility and two-tier rotation
    //----------------------------------------------------------------
    logic [N-1:0] eligible;
    always_comb begin
        eligible = req & ~request_mask[N-1:0]; // [R05]
        if (auto_en) begin
            eligible = eligible & ~timeout_status[N-1:0]; // [R12]
        end
    end

    logic hi_any, lo_any;
    logic [W-1:0] hi_pick, lo_pick, last_hi, last_lo, next_last_hi, next_last_lo;
    sbra_rotate #(.N(N)) u_hi (
        .i_req(eligible & i_high_tier),
        .i_last(last_hi),
        .o_any(hi_any),
        .o_pick(hi_pick)
    );
    sbra_rotate #(.N(N)) u_lo (
        .i_req(eligible & ~i_high_tier),
        .i_last(last_lo),
        .o_any(lo_any),
        .o_pick(lo_pick)
    );

    //----------------------------------------------------------------
    // Grant and time-out state machine
    //----------------------------------------------------------------
    sbra_pkg::sbra_state_t state, next_state;
    logic [W-1:0] owner, next_owner;
    logic granted, next_granted;
    logic [4:0] count, next_count;
    logic timeout_pulse, next_timeout_pulse;
    logic [N-1:0] gnt_n, next_gnt_n;
    wire logic bus_idle = ~frame_act & ~irdy_act;

    always_comb begin
        next_state = state;
        next_owner = owner;
        next_granted = granted;
        next_count = count;
        next_last_hi = last_hi;
        next_last_lo = last_lo;
        next_timeout_pulse = 1'b0;
        timeout_set = '0;
        case (state)
            sbra_pkg::SBRA_IDLE: begin
                next_granted = 1'b0;
                if (bus_idle && (hi_any || lo_any)) begin
                    next_granted = 1'b1;
                    next_count = '0;
                    next_state = sbra_pkg::SBRA_WAIT;
                    if (hi_any) begin // [R11]
                        next_owner = hi_pick;
                        next_last_hi = hi_pick;
                    end else begin
                        next_owner = lo_pick;
                        next_last_lo = lo_pick;
                    end
                end
            end
            sbra_pkg::SBRA_WAIT: begin
                if (frame_act) begin
                    next_state = sbra_pkg::SBRA_BUSY;
                end else if (!eligible[owner]) begin
                    // Requester withdrew or was masked: re-arbitrate
                    next_granted = 1'b0;
                    next_state = sbra_pkg::SBRA_IDLE;
                end else if (to_en && bus_idle) begin // [R01]
                    // Window counts idle clocks with grant held
                    if (count == sbra_pkg::TIMEOUT_LAST) begin // [R02] [R03]
                        timeout_set[owner] = 1'b1; // [R06]
                        next_timeout_pulse = 1'b1;
                        next_granted = 1'b0;
                        next_state = sbra_pkg::SBRA_IDLE; // [R12]
                    end else begin
                        next_count = count + 5'h01;
                    end
                end
            end
            sbra_pkg::SBRA_BUSY: begin
                // Hold grant through the owner's transaction, release once idle
                if (bus_idle) begin
                    next_granted = 1'b0;
                    next_state = sbra_pkg::SBRA_IDLE;
                end
            end
            default: begin
                next_granted = 1'b0;
                next_state = sbra_pkg::SBRA_IDLE;
            end
        endcase
        next_gnt_n = '1;
        if (next_granted) begin
            next_gnt_n[next_owner] = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            state <= sbra_pkg::SBRA_IDLE;
            owner <= '0;
            granted <= 1'b0;
            count <= '0;
            last_hi <= W'(N - 1);
            last_lo <= W'(N - 1);
            timeout_pulse <= 1'b0;
            gnt_n <= '1;
        end else begin
            state <= next_state;
            owner <= next_owner;
            granted <= next_granted;
            count <= next_count;
            last_hi <= next_last_hi;
            last_lo <= next_last_lo;
            timeout_pulse <= next_timeout_pulse;
            gnt_n <= next_gnt_n;
        end
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    // Every pin is a plain register copy, so no decode glitch reaches the bus
    assign o_gnt_n = gnt_n;
    assign o_cfg_rdata = rdata;
    assign o_request_timed_out_flags = timeout_status[N-1:0];
    assign o_timeout_pulse = timeout_pulse;
endmodule // sbra_arbiter

// ==== dv/sbra_master_model.sv ====
module sbra_master_model (
    input wire logic i_clk,
    input wire logic [5:0] i_want,
    input wire logic [5:0] i_respond,
    input wire logic [5:0] i_gnt_n,
    output logic [5:0] o_req_n,
    output logic o_frame_n,
    output logic o_irdy_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph = 2'h0;
    assign o_req_n = ~i_want;
    // Released lines sit at the pull-up level
    assign o_frame_n = (ph != 2'h1);
    assign o_irdy_n = (ph == 2'h0) || (ph == 2'h3);
    always @(posedge i_clk) begin
        if (ph != 2'h0) begin
            ph <= #1 ph + 2'h1;
        end else if (|(~i_gnt_n & i_respond & i_want) && o_frame_n && o_irdy_n) begin
            ph <= #1 2'h1;
        end
    end
endmodule // sbra_master_model

// ==== dv/sbra_arbiter_properties.sv ====
module sbra_arbiter_properties #(
    parameter int N = 6
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_reset_pin_n,
    input wire logic i_global_reset_pin_n,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic [N-1:0] o_gnt_n,
    input wire logic [N-1:0] o_request_timed_out_flags,
    input wire logic o_timeout_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pins_low;
    assign pins_low = !i_link_reset_pin_n || !i_global_reset_pin_n;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_one_grant; $onehot0(~o_gnt_n); endproperty
    a_one_grant: assert property (p_one_grant) else $error("two grants");
    property p_pulse_single; o_timeout_pulse |=> !o_timeout_pulse; endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("long pulse");
    property p_flag_cause; |(o_request_timed_out_flags & ~$past(o_request_timed_out_flags))
        |-> o_timeout_pulse; endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without pulse");
    property p_owner_flag; o_timeout_pulse |-> |(o_request_timed_out_flags
        & ~$past(o_gnt_n)); endproperty
    a_owner_flag: assert property (p_owner_flag) else $error("owner flag clear");
    property p_grant_drop; o_timeout_pulse |-> &o_gnt_n; endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("grant kept");
    property p_window; o_timeout_pulse |-> $past(o_gnt_n) == $past(o_gnt_n, 16)
        && $past(o_gnt_n) != '1; endproperty
    a_window: assert property (p_window) else $error("early time-out");
    property p_status_read; $past(i_cfg_rd) && $past(i_cfg_addr) == 8'hde
        |-> o_cfg_rdata == {2'h0, $past(o_request_timed_out_flags)}; endproperty
    a_status_read: assert property (p_status_read) else $error("status read");
    property p_flag_hold; |($past(o_request_timed_out_flags) & ~o_request_timed_out_flags)
        |-> ($past(i_cfg_wr) && $past(i_cfg_addr) == 8'hde) || $past(pins_low, 2)
        || $past(pins_low, 3); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_reset_vals; $past(i_rst) |-> &o_gnt_n && o_request_timed_out_flags == '0
        && !o_timeout_pulse && o_cfg_rdata == 8'h00; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values");
endmodule // sbra_arbiter_properties
bind sbra_arbiter sbra_arbiter_properties #(.N(N)) u_props (.i_clk(i_clk), .i_rst(i_rst),
    .i_link_reset_pin_n(i_link_reset_pin_n), .i_global_reset_pin_n(i_global_reset_pin_n),
    .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
    .o_cfg_rdata(o_cfg_rdata), .o_gnt_n(o_gnt_n),
    .o_request_timed_out_flags(o_request_timed_out_flags), .o_timeout_pulse(o_timeout_pulse));

// ==== dv/sbra_arbiter_tb.sv ====
module sbra_arbiter_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic lrst_n = 1'b1;
    logic global_reset_pin_n = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [5:0] want = 6'h00;
    logic [5:0] resp = 6'h3f;
    logic [5:0] tier = 6'h00;
    logic [7:0] rdata;
    logic [5:0] req_n, gnt_n, flags;
    logic frame_n, irdy_n, pulse;
    int fails = 0;
    int checked = 0;
    sbra_arbiter dut (.i_clk(i_clk), .i_rst(i_rst), .i_link_reset_pin_n(lrst_n),
        .i_global_reset_pin_n(global_reset_pin_n), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_req_n(req_n), .i_high_tier(tier),
        .i_frame_n(frame_n), .i_irdy_n(irdy_n), .o_gnt_n(gnt_n),
        .o_request_timed_out_flags(flags), .o_timeout_pulse(pulse));
    sbra_master_model masters (.i_clk(i_clk), .i_want(want), .i_respond(resp),
        .i_gnt_n(gnt_n), .o_req_n(req_n), .o_frame_n(frame_n), .o_irdy_n(irdy_n));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
        tick(1);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        tick(1);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
        cfg(1'b0, a, 8'h00);
        chk(what, e, rdata);
    endtask
    task automatic wait_gnt(input logic [5:0] exp);
        for (int n = 0; n < 60 && gnt_n === 6'h3f; n++) tick(1);
        chk("grant", {2'h0, exp}, {2'h0, ~gnt_n});
    endtask
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        tick(2);
        i_rst = 1'b0;
        rdc("mask", 8'hdd, 8'h00);
        rdc("status", 8'hde, 8'h00);
        cfg(1'b1, 8'hdd, 8'h01);
        want = 6'h01;
        tick(20);
        chk("masked", 8'h3f, {2'h0, gnt_n});
        cfg(1'b1, 8'hdd, 8'h00);
        wait_gnt(6'h01);
        want = 6'h00;
        tick(10);
        tier = 6'h20;
        want = 6'h21;
        wait_gnt(6'h20);
        tick(4);
        want = 6'h01;
        tick(8);
        wait_gnt(6'h01);
        want = 6'h00;
        tick(8);
        resp = 6'h00;
        want = 6'h04;
        tick(40);
        chk("no timeout", 8'h00, {2'h0, flags});
        cfg(1'b1, 8'hdd, 8'h80);
        // The grant is already held, so the window starts with the enable write
        tick(15);
        chk("window early", 8'h00, {2'h0, flags});
        tick(1);
        chk("window end", 8'h04, {2'h0, flags});
        chk("pulse", 8'h01, {7'h00, pulse});
        chk("released", 8'h3f, {2'h0, gnt_n});
        tick(4);
        want = 6'h00;
        tick(6);
        rdc("status", 8'hde, 8'h04);
        rdc("unmapped", 8'hdc, 8'h00);
        cfg(1'b1, 8'hde, 8'hfb);
        rdc("status", 8'hde, 8'h04);
        cfg(1'b1, 8'hde, 8'hff);
        rdc("status", 8'hde, 8'h00);
        cfg(1'b1, 8'hdd, 8'hc0);
        want = 6'h02;
        tick(30);
        chk("auto mask", 8'h3f, {2'h0, gnt_n});
        want = 6'h00;
        cfg(1'b1, 8'hde, 8'h02);
        rdc("status", 8'hde, 8'h02);
        cfg(1'b1, 8'hdd, 8'h80);
        cfg(1'b1, 8'hde, 8'h02);
        rdc("status", 8'hde, 8'h00);
        for (int k = 0; k < 2; k++) begin
            cfg(1'b1, 8'hdd, 8'hff);
            lrst_n = (k != 0);
            global_reset_pin_n = (k == 0);
            tick(5);
            lrst_n = 1'b1;
            global_reset_pin_n = 1'b1;
            tick(3);
            rdc("mask", 8'hdd, 8'h00);
        end
        finish_test();
    end
    initial begin
        #20us;
        fails++;
        finish_test();
    end
endmodule // sbra_arbiter_tb
